// >>> tma_pkg.sv
// constants, types and register layout of the temperature monitor status block
package tma_pkg;
    localparam logic [7:0] PTR_STATUS = 8'h02;
    localparam logic [7:0] PTR_CFG_RD = 8'h03;
    localparam logic [7:0] PTR_CFG_WR = 8'h09;
    localparam logic [7:0] PTR_ONE_SHOT = 8'h0F;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] CFG_WRITABLE = 8'hE4;
    localparam logic [7:0] READ_NONE = 8'h00;
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_SHUTDOWN_BIT = 6;
    localparam int CFG_PIN_BIT = 5;
    localparam int CFG_RANGE_BIT = 2;
    // per-channel status layout
    localparam int PC_BUSY = 7;
    localparam int PC_LOCAL_UPPER = 6;
    localparam int PC_LOCAL_LOWER = 5;
    localparam int PC_REMOTE_UPPER = 4;
    localparam int PC_REMOTE_LOWER = 3;
    localparam int PC_OPEN = 2;
    localparam int PC_REMOTE_OVERTEMP = 1;
    localparam int PC_LOCAL_OVERTEMP = 0;
    // merged status layout
    localparam int MG_BUSY = 7;
    localparam int MG_UPPER = 4;
    localparam int MG_LOWER = 3;
    localparam int MG_OPEN = 2;
    localparam int MG_OVERTEMP = 1;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int NUM_CHAN = 3;
    localparam logic [1:0] CH_LOCAL = 2'h0;
    localparam logic [3:0] COUNT_MAX = 4'hF;
    localparam logic [3:0] COUNT_ONE = 4'h1;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    localparam logic [7:0] TEMP_ZERO = 8'h00;

    typedef enum logic [1:0] {
        TMA_RUN = 2'b00,
        TMA_SHUT = 2'b01,
        TMA_ONE_SHOT = 2'b11
    } tma_mode_t;
endpackage

// >>> tma_channel.sv
// comparator and hysteresis state of one measurement channel
`timescale 1ns/100ps
`default_nettype none
module tma_channel
    import tma_pkg::*;
(
    input wire logic clk, // block clock
    input wire logic rst, // synchronous reset
    input wire logic upd, // conversion of this channel finished
    input wire logic [7:0] temp, // converted temperature code
    input wire logic [7:0] upper_limit, // upper limit code
    input wire logic [7:0] lower_limit, // lower limit code
    input wire logic [7:0] overtemp_limit, // thermal limit code
    input wire logic [7:0] hyst, // shared hysteresis, unsigned
    input wire logic [3:0] queue, // consecutive out-of-limit count needed
    output logic overtemp, // live overtemperature comparator
    output logic upper_hyst, // live upper comparator with hysteresis
    output logic upper_now, // last result above upper limit
    output logic lower_now, // last result below lower limit
    output logic queue_met // enough consecutive out-of-limit results
);
    typedef struct packed {
        logic overtemp;
        logic upper_hyst;
        logic upper_now;
        logic lower_now;
        logic [3:0] count;
    } tma_chan_state_t;

    tma_chan_state_t s_q, s_d;
    logic [7:0] ot_release;
    logic [7:0] up_release;
    logic above_up;
    logic below_lo;

    // hysteresis is unsigned; saturate at zero instead of wrapping
    assign ot_release = (overtemp_limit > hyst) ? overtemp_limit - hyst : TEMP_ZERO;
    assign up_release = (upper_limit > hyst) ? upper_limit - hyst : TEMP_ZERO;
    assign above_up = temp > upper_limit;
    assign below_lo = temp < lower_limit;

    always_comb begin
        s_d = s_q;
        // limits only matter at the end of a conversion
        if (upd) begin
            s_d.upper_now = above_up;
            s_d.lower_now = below_lo;
            if (temp > overtemp_limit) begin
                s_d.overtemp = 1'b1;
            end else if (temp <= ot_release) begin
                s_d.overtemp = 1'b0;
            end
            if (above_up) begin
                s_d.upper_hyst = 1'b1;
            end else if (temp <= up_release) begin
                s_d.upper_hyst = 1'b0;
            end
            if (above_up || below_lo) begin
                if (s_q.count != COUNT_MAX) begin
                    s_d.count = s_q.count + COUNT_ONE;
                end
            end else begin
                s_d.count = COUNT_ZERO;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign overtemp = s_q.overtemp;
    assign upper_hyst = s_q.upper_hyst;
    assign upper_now = s_q.upper_now;
    assign lower_now = s_q.lower_now;
    // a queue of zero behaves as one
    assign queue_met = (s_q.count != COUNT_ZERO) && (s_q.count >= queue);
endmodule
`default_nettype wire

// >>> tma_status_top.sv
// status flags, alert pin and primary configuration of the temperature monitor
// How it works
// - status at 02h read-only, writes ignored
// - busy bit mirrors converter activity from reset
// - open flag set by remote conversions, held
// - per-channel overtemp flags with shared hysteresis
// - alert mode: upper flags latch on exceed
// - thermal mode: upper flags live with hysteresis
// - lower flags latch regardless of pin mode
// - latched flags clear on read if gone
// - live flags ignore reads, update per conversion
// - per-channel flag rise pulls alert low in alert mode; overtemp flags never do
// - merged status bit layout, reset zero
// - merged overtemp flag any channel, hysteresis
// - merged upper flag latched or live
// - merged lower flag latches on any channel
// - merged flag rise pulls alert low in alert mode; overtemp flag never does
// - config written 09h, read 03h, reserved zero
// - mask blocks alert pin in alert mode
// - alert needs consecutive out-of-limit results
// - shutdown bit stops and resumes conversion
// - one-shot write in shutdown: one sequence
// - pin mode bit selects alert or thermal
// - range bit selects result format
// - per-channel status bit order, reset zero
// - compare limits only at conversion end
// - hysteresis unsigned, never negative
`timescale 1ns/100ps
`default_nettype none
module tma_status_top
    import tma_pkg::*;
#(
    parameter bit MERGED = 1'b0 // 1 selects the merged multi-channel status layout
) (
    input wire logic CLOCK, // 20 MHz block clock
    input wire logic RESET, // synchronous reset, active high
    input wire logic REG_WR, // register write strobe, one cycle
    input wire logic REG_RD, // register read strobe, one cycle
    input wire logic [7:0] REG_PTR, // register pointer
    input wire logic [7:0] REG_WDATA, // write data
    output logic [7:0] REG_RDATA, // read data, valid the cycle after REG_RD
    input wire logic CONV_BUSY, // converter is converting
    input wire logic CONV_DONE, // one channel conversion finished, one cycle
    input wire logic [1:0] CONV_CHAN, // channel of that conversion: 0 local, 1 and 2 remote
    input wire logic [7:0] CONV_TEMP, // converted temperature code
    input wire logic CONV_OPEN, // remote diode seen open in that conversion
    input wire logic SEQ_DONE, // full conversion sequence finished, one cycle
    input wire logic [23:0] UPPER_LIMITS, // upper limits, channel 0 in low byte
    input wire logic [23:0] LOWER_LIMITS, // lower limits, channel 0 in low byte
    input wire logic [23:0] OVERTEMP_LIMITS, // thermal limits, channel 0 in low byte
    input wire logic [7:0] HYSTERESIS, // shared hysteresis code
    input wire logic [3:0] FAULT_QUEUE, // consecutive results before alert
    output logic CONV_RUN, // converter may run
    output logic RANGE_EXTENDED, // 1 selects extended offset format
    input wire logic ALERT_PIN_IN, // level seen on the open-drain pin
    output logic ALERT_PIN_OUT, // value driven on the pin, always low
    output logic ALERT_PIN_OE // high while the pin is pulled low
);
    typedef struct packed {
        logic [7:0] cfg;
        tma_mode_t mode;
        logic loc_up;
        logic rem_up;
        logic loc_lo;
        logic rem_lo;
        logic open;
        logic open_now;
        logic alert;
        logic [7:0] rdata;
    } tma_top_state_t;

    tma_top_state_t s_q, s_d;

    logic [NUM_CHAN-1:0] ch_upd;
    logic [NUM_CHAN-1:0] ch_overtemp;
    logic [NUM_CHAN-1:0] ch_up_hyst;
    logic [NUM_CHAN-1:0] ch_up_now;
    logic [NUM_CHAN-1:0] ch_lo_now;
    logic [NUM_CHAN-1:0] ch_queue;
    logic status_rd;
    logic pin_thermal;
    logic loc_up_flag;
    logic rem_up_flag;
    logic any_alert_flag;
    logic [7:0] status_pc;
    logic [7:0] status_mg;
    logic [7:0] status_val;
    logic pin_low;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : g_chan
            assign ch_upd[gi] = CONV_DONE && (CONV_CHAN == 2'(gi));
            tma_channel u_chan (
                .clk(CLOCK),
                .rst(RESET),
                .upd(ch_upd[gi]),
                .temp(CONV_TEMP),
                .upper_limit(UPPER_LIMITS[gi*8 +: 8]),
                .lower_limit(LOWER_LIMITS[gi*8 +: 8]),
                .overtemp_limit(OVERTEMP_LIMITS[gi*8 +: 8]),
                .hyst(HYSTERESIS),
                .queue(FAULT_QUEUE),
                .overtemp(ch_overtemp[gi]),
                .upper_hyst(ch_up_hyst[gi]),
                .upper_now(ch_up_now[gi]),
                .lower_now(ch_lo_now[gi]),
                .queue_met(ch_queue[gi])
            );
        end
    endgenerate

    assign status_rd = REG_RD && (REG_PTR == PTR_STATUS);
    assign pin_thermal = s_q.cfg[CFG_PIN_BIT];

    // high flags: latched in alert mode, live comparators in thermal mode
    assign loc_up_flag = pin_thermal ? ch_up_hyst[0] : s_q.loc_up;
    assign rem_up_flag = pin_thermal ? |ch_up_hyst[NUM_CHAN-1:1] : s_q.rem_up;

    // flags that feed the alert output in alert mode
    assign any_alert_flag = s_q.loc_up | s_q.rem_up | s_q.loc_lo | s_q.rem_lo | s_q.open;

    always_comb begin
        status_pc = STATUS_RESET;
        status_pc[PC_BUSY] = CONV_BUSY;
        status_pc[PC_LOCAL_UPPER] = loc_up_flag;
        status_pc[PC_LOCAL_LOWER] = s_q.loc_lo;
        status_pc[PC_REMOTE_UPPER] = rem_up_flag;
        status_pc[PC_REMOTE_LOWER] = s_q.rem_lo;
        status_pc[PC_OPEN] = s_q.open;
        status_pc[PC_REMOTE_OVERTEMP] = |ch_overtemp[NUM_CHAN-1:1];
        status_pc[PC_LOCAL_OVERTEMP] = ch_overtemp[0];
    end

    always_comb begin
        status_mg = STATUS_RESET;
        status_mg[MG_BUSY] = CONV_BUSY;
        status_mg[MG_UPPER] = loc_up_flag | rem_up_flag;
        status_mg[MG_LOWER] = s_q.loc_lo | s_q.rem_lo;
        status_mg[MG_OPEN] = s_q.open;
        status_mg[MG_OVERTEMP] = |ch_overtemp;
    end

    assign status_val = MERGED ? status_mg : status_pc;

    always_comb begin
        s_d = s_q;

        // configuration: only the defined bits are kept
        if (REG_WR && (REG_PTR == PTR_CFG_WR)) begin
            s_d.cfg = REG_WDATA & CFG_WRITABLE;
        end
        // a write to the status pointer decodes to nothing

        // read data is captured before any clear takes effect
        if (REG_RD) begin
            case (REG_PTR)
                PTR_STATUS: s_d.rdata = status_val;
                PTR_CFG_RD: s_d.rdata = s_q.cfg;
                default: s_d.rdata = READ_NONE;
            endcase
        end

        // open condition of the most recent remote conversion
        if (CONV_DONE && (CONV_CHAN != CH_LOCAL)) begin
            s_d.open_now = CONV_OPEN;
        end

        // latched flags: the live condition sets, a status read clears only when
        // the condition is gone; the set term wins in the same cycle
        s_d.loc_up = ch_up_now[0] | (s_q.loc_up & ~status_rd);
        s_d.rem_up = (|ch_up_now[NUM_CHAN-1:1]) | (s_q.rem_up & ~status_rd);
        s_d.loc_lo = ch_lo_now[0] | (s_q.loc_lo & ~status_rd);
        s_d.rem_lo = (|ch_lo_now[NUM_CHAN-1:1]) | (s_q.rem_lo & ~status_rd);
        s_d.open = s_q.open_now | (s_q.open & ~status_rd);

        // in alert mode alert holds while flags stay set; it needs the consecutive count; thermal mode clears it
        if (pin_thermal) begin
            s_d.alert = 1'b0;
        end else if (any_alert_flag && (|ch_queue)) begin
            s_d.alert = 1'b1;
        end else if (!any_alert_flag) begin
            s_d.alert = 1'b0;
        end

        // conversion control
        case (s_q.mode)
            TMA_RUN: begin
                if (s_d.cfg[CFG_SHUTDOWN_BIT]) begin
                    s_d.mode = TMA_SHUT;
                end
            end
            TMA_SHUT: begin
                // clearing shutdown resumes on the write edge itself
                if (!s_d.cfg[CFG_SHUTDOWN_BIT]) begin
                    s_d.mode = TMA_RUN;
                end else if (REG_WR && (REG_PTR == PTR_ONE_SHOT)) begin
                    s_d.mode = TMA_ONE_SHOT;
                end
            end
            TMA_ONE_SHOT: begin
                // one sequence, then back to shutdown; clearing the shutdown bit goes to run instead
                if (SEQ_DONE) begin
                    s_d.mode = s_d.cfg[CFG_SHUTDOWN_BIT] ? TMA_SHUT : TMA_RUN;
                end else if (!s_d.cfg[CFG_SHUTDOWN_BIT]) begin
                    s_d.mode = TMA_RUN;
                end
            end
            default: s_d.mode = TMA_SHUT;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            s_q <= '{cfg: CFG_RESET, mode: TMA_RUN, rdata: READ_NONE, default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // running from reset lets the first conversion start at once
    // shutdown cuts the run request in the same cycle the bit is set
    assign CONV_RUN = ((s_q.mode == TMA_RUN) || (s_q.mode == TMA_ONE_SHOT)) &&
                      !(s_q.cfg[CFG_SHUTDOWN_BIT] && (s_q.mode == TMA_RUN));
    assign RANGE_EXTENDED = s_q.cfg[CFG_RANGE_BIT];

    // mask only gates the pin; the alert state is retained underneath
    assign pin_low = pin_thermal ? (loc_up_flag | rem_up_flag)
                                 : (s_q.alert & ~s_q.cfg[CFG_MASK_BIT]);

    assign REG_RDATA = s_q.rdata;
    assign ALERT_PIN_OUT = 1'b0;
    assign ALERT_PIN_OE = pin_low;
endmodule
`default_nettype wire

// >>> tma_status_checker.sv
// assertions on the status block's register bus, converter control and alert pin
`timescale 1ns/100ps
`default_nettype none
module tma_status_checker
    import tma_pkg::*;
(
    input wire logic CLOCK, // block clock
    input wire logic RESET, // synchronous reset
    input wire logic REG_WR, // write strobe
    input wire logic REG_RD, // read strobe
    input wire logic [7:0] REG_PTR, // pointer
    input wire logic [7:0] REG_WDATA, // write data
    input wire logic [7:0] REG_RDATA, // read data
    input wire logic CONV_BUSY, // converter busy
    input wire logic CONV_RUN, // converter may run
    input wire logic RANGE_EXTENDED, // range select
    input wire logic ALERT_PIN_OE // pin pulled low
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    cfg_read_clean_a: assert property (REG_RD && REG_PTR == PTR_CFG_RD |=> (REG_RDATA & ~CFG_WRITABLE) == 8'h00)
        else $error("reserved configuration bits read back set");
    unmapped_read_a: assert property (REG_RD && REG_PTR != PTR_STATUS && REG_PTR != PTR_CFG_RD |=> REG_RDATA == READ_NONE)
        else $error("unmapped pointer returned data");
    busy_capture_a: assert property (REG_RD && REG_PTR == PTR_STATUS |=> REG_RDATA[PC_BUSY] == $past(CONV_BUSY))
        else $error("busy bit does not follow converter");
    rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    shutdown_stop_a: assert property (REG_WR && REG_PTR == PTR_CFG_WR && REG_WDATA[CFG_SHUTDOWN_BIT] |=> !CONV_RUN)
        else $error("shutdown did not stop conversion");
    run_resume_a: assert property (REG_WR && REG_PTR == PTR_CFG_WR && !REG_WDATA[CFG_SHUTDOWN_BIT] |=> CONV_RUN)
        else $error("clearing shutdown did not resume");
    range_follow_a: assert property (REG_WR && REG_PTR == PTR_CFG_WR |=> RANGE_EXTENDED == $past(REG_WDATA[CFG_RANGE_BIT]))
        else $error("range output does not follow write");
    mask_block_a: assert property (REG_WR && REG_PTR == PTR_CFG_WR && REG_WDATA[CFG_MASK_BIT] &&
        !REG_WDATA[CFG_PIN_BIT] |=> !ALERT_PIN_OE)
        else $error("masked alert still pulls pin");
    one_shot_start_a: assert property (REG_WR && REG_PTR == PTR_ONE_SHOT && !CONV_RUN ##1 !REG_WR |-> CONV_RUN)
        else $error("one-shot write did not start a sequence");
endmodule
`default_nettype wire

// >>> tma_host_model.sv
// register host model driving the block's one-cycle strobe interface
`timescale 1ns/100ps
`default_nettype none
module tma_host_model (
    input wire logic CLOCK, // block clock
    output logic REG_WR, // write strobe
    output logic REG_RD, // read strobe
    output logic [7:0] REG_PTR, // pointer
    output logic [7:0] REG_WDATA, // write data
    input wire logic [7:0] REG_RDATA // read data
);
    initial begin
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_PTR = 8'h00;
        REG_WDATA = 8'h00;
    end
    // idle bus shows inverted values so stale data never looks valid
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        @(negedge CLOCK);
        REG_WR = 1'b1;
        REG_PTR = p;
        REG_WDATA = d;
        @(negedge CLOCK);
        REG_WR = 1'b0;
        REG_PTR = ~p;
        REG_WDATA = ~d;
    endtask
    // data is registered by the edge that takes the strobe
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        @(negedge CLOCK);
        REG_RD = 1'b1;
        REG_PTR = p;
        @(negedge CLOCK);
        REG_RD = 1'b0;
        REG_PTR = ~p;
        d = REG_RDATA;
    endtask
endmodule
`default_nettype wire

// >>> tma_status_top_test.sv
// self-checking bench for the status block in both status layouts
`timescale 1ns/100ps
`default_nettype none
module tma_status_top_test
    import tma_pkg::*;
;
    logic CLOCK = 1'b0;
    logic RESET = 1'b1;
    logic cb, cd, co, sd, wr_s, rd_s, run, rext, pout, poe, line, poe_m;
    logic [1:0] cch;
    logic [3:0] fq;
    logic [7:0] ct, rv, ptr, wdat, rdat, rdat_m;
    logic [23:0] ul = 24'h60_6060;
    int err_count = 0;
    int num_checks = 0;
    always #25 CLOCK = ~CLOCK;
    assign line = poe ? pout : 1'b1; // pulled up when released
    tma_status_top u_tma_status_top (.CLOCK(CLOCK), .RESET(RESET), .REG_WR(wr_s), .REG_RD(rd_s),
        .REG_PTR(ptr), .REG_WDATA(wdat), .REG_RDATA(rdat), .CONV_BUSY(cb), .CONV_DONE(cd), .CONV_CHAN(cch),
        .CONV_TEMP(ct), .CONV_OPEN(co), .SEQ_DONE(sd), .UPPER_LIMITS(ul), .LOWER_LIMITS(24'h10_1010),
        .OVERTEMP_LIMITS(24'h50_5050), .HYSTERESIS(8'h0A), .FAULT_QUEUE(fq), .CONV_RUN(run),
        .RANGE_EXTENDED(rext), .ALERT_PIN_IN(line), .ALERT_PIN_OUT(pout), .ALERT_PIN_OE(poe));
    tma_host_model u_tma_host_model (.CLOCK(CLOCK), .REG_WR(wr_s), .REG_RD(rd_s), .REG_PTR(ptr),
        .REG_WDATA(wdat), .REG_RDATA(rdat));
    // merged layout sees the same traffic; its read data is captured on the same strobes
    tma_status_top #(.MERGED(1'b1)) u_tma_status_top_merged (.CLOCK(CLOCK), .RESET(RESET), .REG_WR(wr_s),
        .REG_RD(rd_s), .REG_PTR(ptr), .REG_WDATA(wdat), .REG_RDATA(rdat_m), .CONV_BUSY(cb), .CONV_DONE(cd),
        .CONV_CHAN(cch), .CONV_TEMP(ct), .CONV_OPEN(co), .SEQ_DONE(sd), .UPPER_LIMITS(ul),
        .LOWER_LIMITS(24'h10_1010), .OVERTEMP_LIMITS(24'h50_5050), .HYSTERESIS(8'h0A), .FAULT_QUEUE(fq),
        .CONV_RUN(), .RANGE_EXTENDED(), .ALERT_PIN_IN(1'b1), .ALERT_PIN_OUT(), .ALERT_PIN_OE(poe_m));
    task automatic give_verdict();
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
        u_tma_host_model.rd(p, rv);
        chk($sformatf("pointer %h", p), rv, exp);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        u_tma_host_model.wr(p, d);
    endtask
    task automatic pin(input logic exp);
        chk("alert pin", {7'h00, line}, {7'h00, exp});
    endtask
    task automatic runs(input logic exp);
        chk("run", {7'h00, run}, {7'h00, exp});
    endtask
    // flags settle two edges after the done pulse
    task automatic conv(input logic [1:0] ch, input logic [7:0] t, input logic op);
        @(negedge CLOCK);
        cd = 1'b1;
        cch = ch;
        ct = t;
        co = op;
        @(negedge CLOCK);
        cd = 1'b0;
        ct = ~t;
        co = ~op;
        repeat (2) @(negedge CLOCK);
    endtask
    initial begin
        #(50 * 4000);
        err_count++;
        give_verdict();
    end
    initial begin
        cb = 1'b0;
        cd = 1'b0;
        co = 1'b0;
        sd = 1'b0;
        cch = 2'h0;
        ct = 8'h00;
        fq = 4'h1;
        repeat (10) @(negedge CLOCK);
        RESET = 1'b0;
        rchk(PTR_STATUS, STATUS_RESET);
        rchk(PTR_CFG_RD, CFG_RESET);
        runs(1'b1);
        wr(PTR_CFG_WR, 8'hE4);
        rchk(PTR_CFG_RD, 8'hE4);
        chk("range", {7'h00, rext}, 8'h01);
        runs(1'b0);
        wr(PTR_ONE_SHOT, 8'h00);
        runs(1'b1);
        repeat (3) @(negedge CLOCK);
        sd = 1'b1;
        @(negedge CLOCK);
        sd = 1'b0;
        @(negedge CLOCK);
        runs(1'b0);
        wr(PTR_STATUS, 8'hFF);
        rchk(PTR_STATUS, 8'h00);
        rchk(8'h7E, READ_NONE);
        wr(PTR_CFG_WR, 8'h00);
        runs(1'b1);
        chk("range", {7'h00, rext}, 8'h00);
        // two results needed before the pin falls
        fq = 4'h2;
        conv(2'h0, 8'h61, 1'b0);
        pin(1'b1);
        conv(2'h0, 8'h62, 1'b0);
        pin(1'b0);
        chk("merged alert", {7'h00, poe_m}, 8'h01);
        rchk(PTR_STATUS, 8'h41);
        chk("merged status", rdat_m, 8'h12);
        conv(2'h0, 8'h48, 1'b0);
        rchk(PTR_STATUS, 8'h41);
        rchk(PTR_STATUS, 8'h01);
        // alert releases one edge after the last latched flag clears
        @(negedge CLOCK);
        pin(1'b1);
        conv(2'h0, 8'h46, 1'b0);
        rchk(PTR_STATUS, 8'h00);
        conv(2'h2, 8'h0F, 1'b0);
        conv(2'h0, 8'h20, 1'b1);
        rchk(PTR_STATUS, 8'h08);
        chk("merged status", rdat_m, 8'h08);
        conv(2'h1, 8'h20, 1'b1);
        rchk(PTR_STATUS, 8'h0C);
        chk("merged status", rdat_m, 8'h0C);
        conv(2'h1, 8'h20, 1'b0);
        conv(2'h2, 8'h20, 1'b0);
        rchk(PTR_STATUS, 8'h0C);
        rchk(PTR_STATUS, 8'h00);
        fq = 4'h1;
        wr(PTR_CFG_WR, 8'h80);
        conv(2'h1, 8'h70, 1'b0);
        rchk(PTR_STATUS, 8'h12);
        pin(1'b1);
        wr(PTR_CFG_WR, 8'h00);
        pin(1'b0);
        wr(PTR_CFG_WR, 8'hA0);
        pin(1'b0);
        conv(2'h1, 8'h58, 1'b0);
        rchk(PTR_STATUS, 8'h12);
        chk("merged status", rdat_m, 8'h12);
        conv(2'h1, 8'h56, 1'b0);
        rchk(PTR_STATUS, 8'h02);
        chk("merged status", rdat_m, 8'h02);
        pin(1'b1);
        // a limit change alone must not move any flag
        ul = 24'h40_4040;
        repeat (3) @(negedge CLOCK);
        pin(1'b1);
        cb = 1'b1;
        rchk(PTR_STATUS, 8'h82);
        chk("merged status", rdat_m, 8'h82);
        give_verdict();
    end
endmodule
bind tma_status_top tma_status_checker u_tma_status_checker (.CLOCK(CLOCK), .RESET(RESET), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_PTR(REG_PTR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CONV_BUSY(CONV_BUSY),
    .CONV_RUN(CONV_RUN), .RANGE_EXTENDED(RANGE_EXTENDED), .ALERT_PIN_OE(ALERT_PIN_OE));
`default_nettype wire
